// ---- hdl/t1rx_regs.sv ----
// T1 receive signalling-change flags, frame state and alarm controls.
// Assumes framer events are mclk-synchronous pulses; frame state and
// the CAS configuration level arrive from pins and are synchronised.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "t1rx_consts.svh"
module t1rx_regs import t1rx_pkg::*; #(
	parameter int NTS = 24	// Timeslots
) (
	// Clock and reset
	input  wire logic           mclk,
	input  wire logic           resetn,
	// AXI4-Lite write
	input  wire logic [13:0]    s_axi_awaddr,
	input  wire logic           s_axi_awvalid,
	output var  logic           s_axi_awready,
	input  wire logic [31:0]    s_axi_wdata,
	input  wire logic [3:0]     s_axi_wstrb,
	input  wire logic           s_axi_wvalid,
	output var  logic           s_axi_wready,
	output var  logic [1:0]     s_axi_bresp,
	output var  logic           s_axi_bvalid,
	input  wire logic           s_axi_bready,
	// AXI4-Lite read
	input  wire logic [13:0]    s_axi_araddr,
	input  wire logic           s_axi_arvalid,
	output var  logic           s_axi_arready,
	output var  logic [31:0]    s_axi_rdata,
	output var  logic [1:0]     s_axi_rresp,
	output var  logic           s_axi_rvalid,
	input  wire logic           s_axi_rready,
	// Framer side
	input  wire logic [NTS-1:0] sig_change,
	input  wire logic           in_frame_pin,
	input  wire logic           cas_mode_pin,
	input  wire logic [7:0]     rx_data_in,
	input  wire logic [7:0]     tx_data_in,
	// Outputs
	output var  logic [7:0]     rx_serial_out,
	output var  logic [7:0]     line_tx_pair,
	output var  logic           framing_alarm_mask,
	output var  logic           irq
);
	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	logic [1:0] pin_q;	// {cas_mode, in_frame}
	t1rx_sync #(.W(2)) u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.d      ({cas_mode_pin, in_frame_pin}),
		.q      (pin_q)
	);
	logic in_frame;	// Synchronised framer state
	logic cas_mode;	// Synchronised CAS configuration
	assign in_frame = pin_q[0];
	assign cas_mode = pin_q[1];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [NTS-1:0] chg_reg,  chg_next;	// Sticky change flags
	logic [7:0]     fr_reg,   fr_next;	// Control bits 5..2
	logic [7:0]     ctl_reg,  ctl_next;	// CAS gate enable
	logic [2:0]     ist_reg,  ist_next;	// Interrupt status
	logic [2:0]     ien_reg,  ien_next;	// Interrupt enable
	logic           inf_d_reg;	// Last frame state, edge detect
	t1rx_phase_e    wph_reg,  wph_next;	// Write phase
	t1rx_phase_e    rph_reg,  rph_next;	// Read phase
	logic           awr_reg, awr_next, wr_reg, wr_next;
	logic [11:0]    wadr_reg, wadr_next;	// Captured word index
	logic [7:0]     wdat_reg, wdat_next;	// Captured low byte
	logic           wstb_reg, wstb_next;	// Low lane strobe
	logic [1:0]     bresp_next, rresp_next;
	logic [31:0]    rdata_next;
	logic           arr_next;
	logic [NTS-1:0] rd_clr;	// Flags cleared by this read
	logic           do_wr;	// Both write halves held

	assign do_wr = awr_reg && wr_reg && (wph_reg == T1RX_IDLE);

	// ----------------------------------------------------------------
	// AXI write path
	// ----------------------------------------------------------------
	// Address and data captured independently, then one response
	always_comb begin
		awr_next   = awr_reg;
		wr_next    = wr_reg;
		wadr_next  = wadr_reg;
		wdat_next  = wdat_reg;
		wstb_next  = wstb_reg;
		wph_next   = wph_reg;
		bresp_next = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			awr_next  = 1'b1;
			wadr_next = s_axi_awaddr[13:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wr_next   = 1'b1;
			wdat_next = s_axi_wdata[7:0];
			wstb_next = s_axi_wstrb[0];
		end
		case (wph_reg)
			T1RX_IDLE: begin
				if (do_wr) begin
					awr_next = 1'b0;
					wr_next  = 1'b0;
					wph_next = T1RX_RESP;
					case (wadr_reg)
						`T1RX_IDX_CHG0, `T1RX_IDX_CHG1, `T1RX_IDX_CHG2,
						`T1RX_IDX_FRAME, `T1RX_IDX_IRQ_STAT,
						`T1RX_IDX_IRQ_EN, `T1RX_IDX_IRQ_CLR,
						`T1RX_IDX_CTRL: bresp_next = T1RX_OKAY;
						default: bresp_next = T1RX_SLVERR;
					endcase
				end
			end
			T1RX_RESP: begin
				if (s_axi_bready) begin
					wph_next = T1RX_IDLE;
				end
			end
			default: wph_next = T1RX_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// AXI read path
	// ----------------------------------------------------------------
	// One cycle from address accept to rvalid; read side effects here
	always_comb begin
		rph_next   = rph_reg;
		rdata_next = s_axi_rdata;
		rresp_next = s_axi_rresp;
		rd_clr     = '0;
		arr_next   = 1'b0;
		case (rph_reg)
			T1RX_IDLE: begin
				arr_next = !s_axi_arready && s_axi_arvalid;
				if (s_axi_arvalid && s_axi_arready) begin
					rph_next   = T1RX_RESP;
					rdata_next = '0;
					rresp_next = T1RX_OKAY;
					case (s_axi_araddr[13:2])
						`T1RX_IDX_CHG0: begin
							rdata_next[7:0] = chg_reg[7:0];
							rd_clr[7:0]     = 8'hFF;
						end
						`T1RX_IDX_CHG1: begin
							rdata_next[7:0] = chg_reg[15:8];
							rd_clr[15:8]    = 8'hFF;
						end
						`T1RX_IDX_CHG2: begin
							rdata_next[7:0] = chg_reg[23:16];
							rd_clr[23:16]   = 8'hFF;
						end
						`T1RX_IDX_FRAME: begin
							// Reserved bits read zero
							rdata_next[7:0] = fr_reg & `T1RX_FR_WMASK;
							rdata_next[`T1RX_FR_INFRAME] = in_frame;
						end
						`T1RX_IDX_IRQ_STAT: rdata_next[2:0] = ist_reg;
						`T1RX_IDX_IRQ_EN:   rdata_next[2:0] = ien_reg;
						`T1RX_IDX_IRQ_CLR:  rdata_next = '0;
						`T1RX_IDX_CTRL:     rdata_next[7:0] = ctl_reg;
						default: rresp_next = T1RX_SLVERR;
					endcase
				end
			end
			T1RX_RESP: begin
				if (s_axi_rready) begin
					rph_next = T1RX_IDLE;
				end
			end
			default: rph_next = T1RX_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Register contents
	// ----------------------------------------------------------------
	// Flag bit k holds timeslot (7-k) of its group: reverse per byte
	logic [NTS-1:0] ev_map;	// Events in register bit order
	genvar gi;
	generate
		for (gi = 0; gi < NTS; gi++) begin : g_map
			assign ev_map[gi] = sig_change[(gi/8)*8 + 7 - (gi%8)];
		end
	endgenerate

	// Set beats clear, CAS mode gates the sets
	always_comb begin
		logic [NTS-1:0] ev;
		ev       = '0;
		ev       = cas_mode ? ev_map : '0;
		chg_next = (chg_reg & ~rd_clr) | ev;
		fr_next  = fr_reg;
		ctl_next = ctl_reg;
		ien_next = ien_reg;
		ist_next = ist_reg;
		if (do_wr && wstb_reg) begin
			case (wadr_reg)
				// Only bits 5..2 writable, rest ignored
				`T1RX_IDX_FRAME:  fr_next = wdat_reg & `T1RX_FR_WMASK;
				`T1RX_IDX_IRQ_EN: ien_next = wdat_reg[2:0];
				`T1RX_IDX_IRQ_CLR: ist_next = ist_reg & ~wdat_reg[2:0];
				`T1RX_IDX_CTRL:   ctl_next = wdat_reg;
				default: ;
			endcase
		end
		// Sticky events: set wins over a same-cycle clear
		if (|ev) begin
			ist_next[`T1RX_IRQ_CHG] = 1'b1;
		end
		if (inf_d_reg && !in_frame && !fr_reg[`T1RX_FR_MASK]) begin
			ist_next[`T1RX_IRQ_LOF] = 1'b1;
		end
		if (!inf_d_reg && in_frame && !fr_reg[`T1RX_FR_MASK]) begin
			ist_next[`T1RX_IRQ_INF] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Data path shaping
	// ----------------------------------------------------------------
	// Yellow clears bit 6 of each octet in the chosen direction
	logic [7:0] rx_d, tx_d;
	always_comb begin
		rx_d = rx_data_in;
		tx_d = tx_data_in;
		if (fr_reg[`T1RX_FR_YEL]) begin
			if (fr_reg[`T1RX_FR_YDIR]) begin
				rx_d[`T1RX_YEL_BIT] = 1'b0;
			end else begin
				tx_d[`T1RX_YEL_BIT] = 1'b0;
			end
		end
		// AIS overrides everything on the receive side
		if (fr_reg[`T1RX_FR_AIS]) begin
			rx_d = 8'hFF;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			chg_reg   <= '0;
			fr_reg    <= `T1RX_RST_BYTE;
			ctl_reg   <= `T1RX_RST_CTRL;
			ist_reg   <= '0;
			ien_reg   <= '0;
			inf_d_reg <= 1'b0;
			wph_reg   <= T1RX_IDLE;
			rph_reg   <= T1RX_IDLE;
			awr_reg   <= 1'b0;
			wr_reg    <= 1'b0;
			wadr_reg  <= '0;
			wdat_reg  <= '0;
			wstb_reg  <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= T1RX_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= T1RX_OKAY;
			s_axi_rdata   <= '0;
			rx_serial_out <= '0;
			line_tx_pair  <= '0;
			framing_alarm_mask <= 1'b0;
			irq           <= 1'b0;
		end else begin
			chg_reg   <= chg_next & {NTS{ctl_reg[`T1RX_CTRL_CAS]}};
			fr_reg    <= fr_next;
			ctl_reg   <= ctl_next;
			ist_reg   <= ist_next;
			ien_reg   <= ien_next;
			inf_d_reg <= in_frame;
			wph_reg   <= wph_next;
			rph_reg   <= rph_next;
			awr_reg   <= awr_next;
			wr_reg    <= wr_next;
			wadr_reg  <= wadr_next;
			wdat_reg  <= wdat_next;
			wstb_reg  <= wstb_next;
			// Ready one cycle, only while that half is not held
			s_axi_awready <= !awr_next && !s_axi_awready && s_axi_awvalid
				&& (wph_reg == T1RX_IDLE);
			s_axi_wready  <= !wr_next && !s_axi_wready && s_axi_wvalid
				&& (wph_reg == T1RX_IDLE);
			s_axi_bvalid  <= (wph_next == T1RX_RESP);
			s_axi_bresp   <= bresp_next;
			s_axi_arready <= arr_next;
			s_axi_rvalid  <= (rph_next == T1RX_RESP);
			s_axi_rresp   <= rresp_next;
			s_axi_rdata   <= rdata_next;
			rx_serial_out <= rx_d;
			line_tx_pair  <= tx_d;
			framing_alarm_mask <= fr_reg[`T1RX_FR_MASK];
			irq           <= |(ist_next & ien_next);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_rd_clears;
		@(posedge mclk) disable iff (!resetn)
		(s_axi_arvalid && s_axi_arready
			&& s_axi_araddr[13:2] == `T1RX_IDX_CHG0 && !cas_mode)
		|=> (chg_reg[7:0] == 8'h00);
	endproperty
	a_rd_clears: assert property (p_rd_clears)
		else $error("change flags not cleared by read");
	property p_set_wins;
		@(posedge mclk) disable iff (!resetn)
		(rd_clr[0] && ev_map[0] && cas_mode && ctl_reg[`T1RX_CTRL_CAS])
		|=> chg_reg[0];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("change lost on clearing read");
	property p_no_cas;
		@(posedge mclk) disable iff (!resetn)
		!cas_mode |=> ((chg_reg & ~$past(chg_reg)) == '0);
	endproperty
	a_no_cas: assert property (p_no_cas)
		else $error("flag set outside CAS mode");
	property p_ts0_map;
		@(posedge mclk) disable iff (!resetn)
		(sig_change[0] && cas_mode && ctl_reg[`T1RX_CTRL_CAS]) |=> chg_reg[7];
	endproperty
	a_ts0_map: assert property (p_ts0_map)
		else $error("timeslot 0 not in bit 7");
	property p_ts8_map;
		@(posedge mclk) disable iff (!resetn)
		(sig_change[8] && cas_mode && ctl_reg[`T1RX_CTRL_CAS]) |=> chg_reg[15];
	endproperty
	a_ts8_map: assert property (p_ts8_map)
		else $error("timeslot 8 not in bit 7");
	property p_ts23_map;
		@(posedge mclk) disable iff (!resetn)
		(sig_change[23] && cas_mode && ctl_reg[`T1RX_CTRL_CAS]) |=> chg_reg[16];
	endproperty
	a_ts23_map: assert property (p_ts23_map)
		else $error("timeslot 23 not in bit 0");
	property p_ais;
		@(posedge mclk) disable iff (!resetn)
		fr_reg[`T1RX_FR_AIS] |=> (rx_serial_out == 8'hFF);
	endproperty
	a_ais: assert property (p_ais)
		else $error("all-ones not driven");
	property p_yel_tx;
		@(posedge mclk) disable iff (!resetn)
		(fr_reg[`T1RX_FR_YEL] && !fr_reg[`T1RX_FR_YDIR])
		|=> !line_tx_pair[`T1RX_YEL_BIT];
	endproperty
	a_yel_tx: assert property (p_yel_tx)
		else $error("yellow bit not cleared on transmit");
	property p_yel_rx;
		@(posedge mclk) disable iff (!resetn)
		(fr_reg[`T1RX_FR_YEL] && fr_reg[`T1RX_FR_YDIR]
			&& !fr_reg[`T1RX_FR_AIS])
		|=> (!rx_serial_out[`T1RX_YEL_BIT] && line_tx_pair == $past(tx_data_in));
	endproperty
	a_yel_rx: assert property (p_yel_rx)
		else $error("yellow direction wrong");
	property p_mask;
		@(posedge mclk) disable iff (!resetn)
		(fr_reg[`T1RX_FR_MASK] && ist_reg[`T1RX_IRQ_LOF] == 1'b0
			&& !(do_wr && wstb_reg))
		|=> !ist_reg[`T1RX_IRQ_LOF];
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked alarm raised");
	property p_inframe;
		@(posedge mclk) disable iff (!resetn)
		(s_axi_arvalid && s_axi_arready
			&& s_axi_araddr[13:2] == `T1RX_IDX_FRAME)
		|=> (s_axi_rdata[`T1RX_FR_INFRAME] == $past(in_frame)
			&& s_axi_rdata[6] == 1'b0 && s_axi_rdata[1:0] == 2'b00);
	endproperty
	a_inframe: assert property (p_inframe)
		else $error("frame state read wrong");
	property p_c_read;
		@(posedge mclk) disable iff (!resetn)
		s_axi_rvalid && s_axi_rready;
	endproperty
	c_read: cover property (p_c_read);
	property p_c_write;
		@(posedge mclk) disable iff (!resetn)
		s_axi_bvalid && s_axi_bready;
	endproperty
	c_write: cover property (p_c_write);
	property p_c_irq;
		@(posedge mclk) disable iff (!resetn)
		irq;
	endproperty
	c_irq: cover property (p_c_irq);
endmodule : t1rx_regs
`default_nettype wire

// ---- include/t1rx_consts.svh ----
// Constants for the T1 receive signalling-change and frame-state block.
// Assumes inclusion by bare name from design and bench files.
`ifndef T1RX_CONSTS_SVH
`define T1RX_CONSTS_SVH

// ----------------------------------------------------------------
// Register word indices (byte address is index times four)
// ----------------------------------------------------------------
`define T1RX_IDX_CHG0      12'h10D
`define T1RX_IDX_CHG1      12'h10E
`define T1RX_IDX_CHG2      12'h10F
`define T1RX_IDX_FRAME     12'h112
`define T1RX_IDX_IRQ_STAT  12'h120
`define T1RX_IDX_IRQ_EN    12'h121
`define T1RX_IDX_IRQ_CLR   12'h122
`define T1RX_IDX_CTRL      12'h123

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define T1RX_FR_INFRAME    7
`define T1RX_FR_AIS        5
`define T1RX_FR_MASK       4
`define T1RX_FR_YEL        3
`define T1RX_FR_YDIR       2
`define T1RX_FR_WMASK      8'h3C
`define T1RX_YEL_BIT       6
`define T1RX_CTRL_CAS      0
`define T1RX_IRQ_CHG       0
`define T1RX_IRQ_LOF       1
`define T1RX_IRQ_INF       2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define T1RX_RST_BYTE      8'h00
`define T1RX_RST_CTRL      8'h01

`endif

// ---- include/t1rx_pkg.sv ----
// Types shared by the T1 receive register block.
// Assumes the constants header is on the include path.
package t1rx_pkg;
	// AXI response codes
	typedef logic [1:0] t1rx_resp_t;
	localparam t1rx_resp_t T1RX_OKAY   = 2'h0;
	localparam t1rx_resp_t T1RX_SLVERR = 2'h2;
	// Bus slave phases
	typedef enum logic [1:0] {T1RX_IDLE, T1RX_RESP} t1rx_phase_e;
endpackage : t1rx_pkg

// ---- hdl/t1rx_sync.sv ----
// Two-flop synchroniser bank for pin-level inputs.
// Assumes inputs are asynchronous levels; only stage two reads stage one.
`timescale 1ns/10ps
`default_nettype none
module t1rx_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// Levels
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] s1_reg;	// First stage, read only by q
	// Plain two-stage capture
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s1_reg <= '0;
			q      <= '0;
		end else begin
			s1_reg <= d;
			q      <= s1_reg;
		end
	end
endmodule : t1rx_sync
`default_nettype wire

// ---- tb/t1rx_line_model.sv ----
// Far-end line model: signalling events, frame and CAS levels, octets.
// Assumes the bench asks for events one mclk cycle ahead.
`timescale 1ns/10ps
`default_nettype none
module t1rx_line_model #(
	parameter logic [7:0] RX_OCTET = 8'hC3,	// Received octet, bit6 set
	parameter logic [7:0] TX_OCTET = 8'h5A	// Egress octet, bit6 set
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// Bench requests
	input  wire logic [23:0] ev_req,
	input  wire logic        frame_lvl,
	input  wire logic        cas_lvl,
	// Line side
	output var  logic [23:0] sig_change,
	output var  logic        in_frame_pin,
	output var  logic        cas_mode_pin,
	output var  logic [7:0]  rx_data_in,
	output var  logic [7:0]  tx_data_in
);
	// ----------------------------------------
	// Event pulses and levels
	// ----------------------------------------
	// One cycle per request, so a change is never reported twice
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sig_change   <= '0;
			in_frame_pin <= 1'b0;
			cas_mode_pin <= 1'b0;
		end else begin
			sig_change   <= ev_req;
			in_frame_pin <= frame_lvl;
			cas_mode_pin <= cas_lvl;
		end
	end
	// Steady octets keep output checks simple
	assign rx_data_in = RX_OCTET;
	assign tx_data_in = TX_OCTET;
endmodule : t1rx_line_model
`default_nettype wire

// ---- tb/t1_rx_cas_change_and_frame_alarm_tb_top.sv ----
// Bench for the T1 receive change-flag and frame-state register block.
// Assumes the register block is the only bus slave and the line model.
`timescale 1ns/10ps
`default_nettype none
`include "t1rx_consts.svh"
module t1_rx_cas_change_and_frame_alarm_tb_top import t1rx_pkg::*;;
	logic        mclk = 1'b0;	// 100 MHz
	logic        resetn = 1'b0;	// Held 20 cycles
	logic [13:0] awaddr = '0, araddr = '0;
	logic        awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0;
	logic [31:0] wdata = '0, rdata;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [23:0] ev_req = '0, sig_change;
	logic        frame_lvl = 0, cas_lvl = 1;
	logic        in_frame_pin, cas_mode_pin, alarm_mask, irq;
	logic [7:0]  rx_in, tx_in, rx_out, tx_out;
	int          mismatches = 0, num_checks = 0;

	always #5 mclk = ~mclk;

	t1rx_line_model u_line (.mclk(mclk), .resetn(resetn),
		.ev_req(ev_req), .frame_lvl(frame_lvl), .cas_lvl(cas_lvl),
		.sig_change(sig_change), .in_frame_pin(in_frame_pin),
		.cas_mode_pin(cas_mode_pin), .rx_data_in(rx_in),
		.tx_data_in(tx_in));
	t1rx_regs u_dut (.mclk(mclk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sig_change(sig_change),
		.in_frame_pin(in_frame_pin), .cas_mode_pin(cas_mode_pin),
		.rx_data_in(rx_in), .tx_data_in(tx_in),
		.rx_serial_out(rx_out), .line_tx_pair(tx_out),
		.framing_alarm_mask(alarm_mask), .irq(irq));

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Word index to byte address
	function automatic logic [13:0] ba(input logic [11:0] idx);
		return {idx, 2'b00};
	endfunction : ba

	// Values sampled at the edge, released only after the handshake
	task automatic wr(input logic [11:0] idx, input logic [7:0] d,
			output logic [1:0] resp);
		int n;
		@(posedge mclk);
		awaddr <= ba(idx); awvalid <= 1; bready <= 1;
		wdata <= {24'h00_0000, d}; wvalid <= 1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (awready === 1'b1) awvalid <= 0;
			if (wready === 1'b1) wvalid <= 0;
		end while (bvalid !== 1'b1 && n < 60);
		resp = bresp;
		bready <= 0;
		if (n >= 60) chk(32'h0000_0000, 32'h0000_0001);
	endtask : wr

	task automatic rd(input logic [11:0] idx, output logic [31:0] d,
			output logic [1:0] resp);
		int n;
		@(posedge mclk);
		araddr <= ba(idx); arvalid <= 1; rready <= 1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (arready === 1'b1) arvalid <= 0;
		end while (rvalid !== 1'b1 && n < 60);
		d = rdata; resp = rresp;
		rready <= 0;
		if (n >= 60) chk(32'h0000_0000, 32'h0000_0001);
	endtask : rd

	// One-cycle signalling change on one timeslot
	task automatic pulse(input int ts);
		@(posedge mclk);
		ev_req <= 24'h00_0001 << ts;
		@(posedge mclk);
		ev_req <= '0;
		repeat (3) @(posedge mclk);
	endtask : pulse

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 3; i++) begin
			rd(`T1RX_IDX_CHG0 + 12'(i), d, r);
			chk(d, 32'h0000_0000);
		end
		rd(`T1RX_IDX_FRAME, d, r);
		chk(d, 32'h0000_0000);
		chk({31'h0, alarm_mask}, 32'h0000_0000);
		rd(12'h3FF, d, r);
		chk({30'h0, r}, {30'h0, T1RX_SLVERR});
		wr(12'h3FF, 8'hFF, r);
		chk({30'h0, r}, {30'h0, T1RX_SLVERR});
		rd(`T1RX_IDX_CTRL, d, r);
		chk(d, {24'h00_0000, `T1RX_RST_CTRL});
		$display("test reset done");
	endtask : t_reset

	// Every timeslot lands on its own bit, and a read clears it
	task automatic t_flags();
		logic [31:0] d;
		logic [1:0]  r;
		for (int ts = 0; ts < 24; ts++) begin
			pulse(ts);
			rd(`T1RX_IDX_CHG0 + 12'(ts / 8), d, r);
			chk(d, 32'h0000_0080 >> (ts % 8));
			rd(`T1RX_IDX_CHG0 + 12'(ts / 8), d, r);
			chk(d, 32'h0000_0000);
		end
		$display("test flags done");
	endtask : t_flags

	task automatic t_nocas();
		logic [31:0] d;
		logic [1:0]  r;
		cas_lvl <= 0;
		repeat (5) @(posedge mclk);
		pulse(5);
		rd(`T1RX_IDX_CHG0, d, r);
		chk(d, 32'h0000_0000);
		cas_lvl <= 1;
		repeat (5) @(posedge mclk);
		// Gate bit off: changes must not be flagged either
		wr(`T1RX_IDX_CTRL, 8'h00, r);
		chk({30'h0, r}, {30'h0, T1RX_OKAY});
		pulse(5);
		rd(`T1RX_IDX_CHG0, d, r);
		chk(d, 32'h0000_0000);
		wr(`T1RX_IDX_CTRL, 8'h01, r);
		$display("test nocas done");
	endtask : t_nocas

	// Event swept across the clearing read: seen exactly once
	task automatic t_race();
		logic [31:0] d1, d2;
		logic [1:0]  r;
		for (int k = 0; k < 6; k++) begin
			fork
				rd(`T1RX_IDX_CHG0, d1, r);
				begin
					repeat (k) @(posedge mclk);
					ev_req <= 24'h00_0001;
					@(posedge mclk);
					ev_req <= '0;
				end
			join
			repeat (3) @(posedge mclk);
			rd(`T1RX_IDX_CHG0, d2, r);
			chk({31'h0, d1[7]} + {31'h0, d2[7]}, 32'h0000_0001);
		end
		$display("test race done");
	endtask : t_race

	// Control bits against both octet paths
	task automatic t_frame();
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  cv [5] = '{8'h20, 8'h08, 8'h0C, 8'h04, 8'h00};
		logic [7:0]  rx [5] = '{8'hFF, 8'hC3, 8'h83, 8'hC3, 8'hC3};
		logic [7:0]  tx [5] = '{8'h5A, 8'h1A, 8'h5A, 8'h5A, 8'h5A};
		frame_lvl <= 1;
		repeat (5) @(posedge mclk);
		wr(`T1RX_IDX_FRAME, 8'hFF, r);
		rd(`T1RX_IDX_FRAME, d, r);
		chk(d, 32'h0000_00BC);
		chk({31'h0, alarm_mask}, 32'h0000_0001);
		// Frame edges while masked raise no status
		wr(`T1RX_IDX_IRQ_CLR, 8'h06, r);
		frame_lvl <= 0;
		repeat (5) @(posedge mclk);
		rd(`T1RX_IDX_IRQ_STAT, d, r);
		chk({30'h0, d[2:1]}, 32'h0000_0000);
		frame_lvl <= 1;
		repeat (5) @(posedge mclk);
		for (int i = 0; i < 5; i++) begin
			wr(`T1RX_IDX_FRAME, cv[i], r);
			repeat (3) @(posedge mclk);
			chk({24'h0, rx_out}, {24'h0, rx[i]});
			chk({24'h0, tx_out}, {24'h0, tx[i]});
		end
		frame_lvl <= 0;
		repeat (5) @(posedge mclk);
		rd(`T1RX_IDX_FRAME, d, r);
		chk(d, 32'h0000_0000);
		// Unmasked loss of frame is recorded
		rd(`T1RX_IDX_IRQ_STAT, d, r);
		chk({30'h0, d[2:1]}, 32'h0000_0001);
		$display("test frame done");
	endtask : t_frame

	// Raise, mask and clear the change interrupt
	task automatic t_irq();
		logic [31:0] d;
		logic [1:0]  r;
		wr(`T1RX_IDX_IRQ_CLR, 8'h07, r);
		wr(`T1RX_IDX_IRQ_EN, 8'h01, r);
		pulse(3);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(`T1RX_IDX_IRQ_CLR, 8'h01, r);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(`T1RX_IDX_IRQ_EN, 8'h00, r);
		pulse(9);
		chk({31'h0, irq}, 32'h0000_0000);
		rd(`T1RX_IDX_IRQ_STAT, d, r);
		chk({31'h0, d[0]}, 32'h0000_0001);
		$display("test irq done");
	endtask : t_irq

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	initial begin
		repeat (20) @(posedge mclk);
		resetn <= 1;
		repeat (4) @(posedge mclk);
		t_reset();
		t_flags();
		t_nocas();
		t_race();
		t_frame();
		t_irq();
		conclude();
	end

	// Whole run is well under 3000 cycles
	initial begin
		#200000;
		mismatches++;
		conclude();
	end
endmodule : t1_rx_cas_change_and_frame_alarm_tb_top
`default_nettype wire
